/* File: verilog/qdl_defs.svh */
/*
 * Constants shared by both ends of the quad converter serial loader:
 * frame layout, synchroniser lanes, timing counts and the host register map.
 * Assumes a 20 MHz system clock on both ends.
 */
`ifndef QDL_DEFS_SVH
`define QDL_DEFS_SVH

// ****************************************
// Frame layout
// ****************************************
`define QDL_WORD_BITS 16
`define QDL_CNT_W 5
`define QDL_LAST_FALL 5'h0f
`define QDL_FULL_CNT 5'h10
`define QDL_DATA_MSB 15
`define QDL_DATA_LSB 4
`define QDL_ADDR_HI_BIT 3
`define QDL_ADDR_LO_BIT 2
`define QDL_SEL_HI_BIT 1
`define QDL_SEL_LO_BIT 0
`define QDL_NUM_CONV 4

// ****************************************
// Device synchroniser lanes
// ****************************************
`define QDL_DS_W 7
`define QDL_DS_FS 0
`define QDL_DS_SCLK 1
`define QDL_DS_SERIAL_IN 2
`define QDL_DS_LD 3
`define QDL_DS_CLR 4
`define QDL_DS_AHI 5
`define QDL_DS_ALO 6
`define QDL_DS_RST 7'h19

// ****************************************
// Timing
// ****************************************
`define QDL_CLK_NS 50
`define QDL_PULSE_NS 80
`define QDL_PULSE_CYC ((`QDL_PULSE_NS + `QDL_CLK_NS - 1) / `QDL_CLK_NS)
`define QDL_HALF_NS 200
`define QDL_HALF_CYC (`QDL_HALF_NS / `QDL_CLK_NS)
`define QDL_TMR_W 4

// ****************************************
// Host register map
// ****************************************
`define QDL_REG_TX 8'h00
`define QDL_REG_CTRL 8'h04
`define QDL_REG_STATUS 8'h08
`define QDL_REG_RX 8'h0c
`define QDL_CTRL_LOAD 0
`define QDL_CTRL_CLEAR 1
`define QDL_ST_BUSY 0
`define QDL_ST_LOAD 1
`define QDL_ST_CLEAR 2

`endif

/* File: verilog/qdl_pkg.sv */
/*
 * Types of the quad converter serial loader.
 * Assumes qdl_defs.svh for the word width; the 12-bit code and state widths are fixed here.
 */
`include "qdl_defs.svh"

package qdl_pkg;
  typedef logic [11:0] qdl_code_t;
  typedef logic [`QDL_WORD_BITS-1:0] qdl_word_t;
  typedef enum logic [2:0] {
    QDL_H_IDLE,
    QDL_H_LEAD,
    QDL_H_HIGH,
    QDL_H_LOW,
    QDL_H_TAIL
  } qdl_host_state_t;
endpackage : qdl_pkg

/* File: verilog/qdl_link_if.sv */
/*
 * Serial load link between host end and converter end.
 * Assumes the bench joins both modports; all wires are plain one-way.
 */
interface qdl_link_if;
  logic frame_sync_n;
  logic shift_clock_in;
  logic serial_in;
  logic serial_chain_out;
  logic load_outputs_n;
  logic clear_all_n;

  modport dev (
    input frame_sync_n,
    input shift_clock_in,
    input serial_in,
    input load_outputs_n,
    input clear_all_n,
    output serial_chain_out
  );

  modport host (
    output frame_sync_n,
    output shift_clock_in,
    output serial_in,
    output load_outputs_n,
    output clear_all_n,
    input serial_chain_out
  );
endinterface : qdl_link_if

/* File: verilog/qdl_sync.sv */
/*
 * Two flip-flop synchroniser, one lane per bit.
 * Assumes inputs are asynchronous to clk_sys; RST sets idle levels.
 */
module qdl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Lanes
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_lane
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        meta_q[i] <= RST[i];
        q[i] <= RST[i];
      end else begin
        meta_q[i] <= d[i];
        q[i] <= meta_q[i];
      end
    end
  end
endmodule : qdl_sync

/* File: verilog/qdl_device.sv */
/*
 * Converter end of the serial loader: input shift register, address check,
 * four input latches, four converter latches, daisy-chain output.
 * Assumes all link pins and address straps are asynchronous to clk_sys and
 * that the shift clock is slow enough (at least 4 clk_sys per phase) to be
 * sampled; the host end makes it so.
 */
//
// Overview of operation
// - Shift register MSB drives chain output
// - Clear low zeroes every converter latch
// - Load low copies input to converter latches
// - Shifting only while frame sync low
// - Sixteenth falling edge loads selected input latch
// - Bits 15..4 carry the 12-bit code
// - Bits 1..0 pick the input latch
// - Bits 3..2 compared with address pins
// - Address mismatch leaves input latches unchanged
// - Chain output shifts regardless of address
// - Serial data sampled at shift clock fall
// - Select 00=A 01=B 10=C 11=D
// - Frame sent MSB first, select low last
// - Chain output changes after falling edge
//
`include "qdl_defs.svh"

module qdl_device
  import qdl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial link
  qdl_link_if.dev link,
  // Device address straps
  input wire logic addr_pin_hi,
  input wire logic addr_pin_lo,
  // Converter latches, index 0 is A
  output qdl_code_t dac_a_q,
  output qdl_code_t dac_b_q,
  output qdl_code_t dac_c_q,
  output qdl_code_t dac_d_q
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [`QDL_DS_W-1:0] pins;
  logic [`QDL_DS_W-1:0] pins_s;

  assign pins[`QDL_DS_FS] = link.frame_sync_n;
  assign pins[`QDL_DS_SCLK] = link.shift_clock_in;
  assign pins[`QDL_DS_SERIAL_IN] = link.serial_in;
  assign pins[`QDL_DS_LD] = link.load_outputs_n;
  assign pins[`QDL_DS_CLR] = link.clear_all_n;
  assign pins[`QDL_DS_AHI] = addr_pin_hi;
  assign pins[`QDL_DS_ALO] = addr_pin_lo;

  // Idle levels at reset keep frame, load and clear inactive
  qdl_sync #(
    .W(`QDL_DS_W),
    .RST(`QDL_DS_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(pins),
    .q(pins_s)
  );

  logic frame_on;
  logic serial_in_s;
  logic load_n_s;
  logic clear_n_s;

  assign frame_on = ~pins_s[`QDL_DS_FS];
  assign serial_in_s = pins_s[`QDL_DS_SERIAL_IN];
  assign load_n_s = pins_s[`QDL_DS_LD];
  assign clear_n_s = pins_s[`QDL_DS_CLR];

  // ****************************************
  // Shift clock edge detection
  // ****************************************
  logic sclk_prev_q;
  logic sclk_fall;
  logic shift_en;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= pins_s[`QDL_DS_SCLK];
    end
  end

  assign sclk_fall = sclk_prev_q & ~pins_s[`QDL_DS_SCLK];
  // Edges outside a frame are ignored entirely
  assign shift_en = frame_on & sclk_fall;

  // ****************************************
  // Input shift register and bit count
  // ****************************************
  qdl_word_t shift_q;
  qdl_word_t shift_d;
  logic [`QDL_CNT_W-1:0] cnt_q;

  // First bit in ends at the top, select low bit arrives last
  assign shift_d = {shift_q[`QDL_WORD_BITS-2:0], serial_in_s};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else if (shift_en) begin
      shift_q <= shift_d;
    end
  end

  // Count saturates so an overlong frame cannot load a second time
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!frame_on) begin
      cnt_q <= '0;
    end else if (sclk_fall && cnt_q != `QDL_FULL_CNT) begin
      cnt_q <= cnt_q + `QDL_CNT_W'(1);
    end
  end

  // ****************************************
  // Daisy-chain output
  // ****************************************
  logic chain_q;

  // Follows the new shift register MSB, so it moves just after a fall and
  // is stable well before the next one
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chain_q <= 1'b0;
    end else if (shift_en) begin
      chain_q <= shift_d[`QDL_WORD_BITS-1];
    end
  end

  assign link.serial_chain_out = chain_q;

  // ****************************************
  // Frame decode
  // ****************************************
  logic last_fall;
  logic addr_ok;
  logic [1:0] sel;
  qdl_code_t code;

  assign last_fall = shift_en & (cnt_q == `QDL_LAST_FALL);
  assign addr_ok = (shift_d[`QDL_ADDR_HI_BIT] == pins_s[`QDL_DS_AHI])
                 & (shift_d[`QDL_ADDR_LO_BIT] == pins_s[`QDL_DS_ALO]);
  assign sel = {shift_d[`QDL_SEL_HI_BIT], shift_d[`QDL_SEL_LO_BIT]};
  assign code = shift_d[`QDL_DATA_MSB:`QDL_DATA_LSB];

  // ****************************************
  // Input and converter latches
  // ****************************************
  qdl_code_t in_q [`QDL_NUM_CONV];
  qdl_code_t dac_q [`QDL_NUM_CONV];

  for (genvar i = 0; i < `QDL_NUM_CONV; i++) begin : g_conv
    // A mismatching address simply never enables the write
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        in_q[i] <= '0;
      end else if (last_fall && addr_ok && sel == 2'(i)) begin
        in_q[i] <= code;
      end
    end

    // Level driven: while load is held low the converter latch is
    // transparent; clear dominates load
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        dac_q[i] <= '0;
      end else if (!clear_n_s) begin
        dac_q[i] <= '0;
      end else if (!load_n_s) begin
        dac_q[i] <= in_q[i];
      end
    end
  end

  // Converter latches are flops, so the outputs are registered
  assign dac_a_q = dac_q[0];
  assign dac_b_q = dac_q[1];
  assign dac_c_q = dac_q[2];
  assign dac_d_q = dac_q[3];

endmodule : qdl_device

/* File: verilog/qdl_host.sv */
/*
 * Host end of the serial loader: APB slave registers, frame generator with a
 * divided shift clock, and load / clear pulse generators.
 * Assumes an APB master on clk_sys and a converter end on the link.
 */
`include "qdl_defs.svh"

module qdl_host
  import qdl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  qdl_link_if.host link
);

  // ****************************************
  // Chain input synchronisation
  // ****************************************
  logic chain_s;

  qdl_sync #(
    .W(1),
    .RST(1'b0)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(link.serial_chain_out),
    .q(chain_s)
  );

  // ****************************************
  // APB slave
  // ****************************************
  logic access;
  logic commit;
  logic mapped;
  logic tx_start;
  logic [1:0] pulse_req;
  logic [1:0] pulse_busy;
  qdl_host_state_t state_q;
  qdl_word_t tx_q;
  qdl_word_t rx_q;
  logic [31:0] rd_d;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  assign access = psel & penable;
  assign mapped = (paddr == `QDL_REG_TX) | (paddr == `QDL_REG_CTRL)
                | (paddr == `QDL_REG_STATUS) | (paddr == `QDL_REG_RX);
  // Writes take effect only on the completing edge
  assign commit = access & pready_q & pwrite & mapped;
  // A frame write while busy is dropped
  assign tx_start = commit & (paddr == `QDL_REG_TX) & (state_q == QDL_H_IDLE);
  assign pulse_req[`QDL_CTRL_LOAD] = commit & (paddr == `QDL_REG_CTRL)
                                   & pwdata[`QDL_CTRL_LOAD];
  assign pulse_req[`QDL_CTRL_CLEAR] = commit & (paddr == `QDL_REG_CTRL)
                                    & pwdata[`QDL_CTRL_CLEAR];

  always_comb begin
    rd_d = '0;
    case (paddr)
      `QDL_REG_TX: rd_d = {16'h0000, tx_q};
      `QDL_REG_STATUS: begin
        rd_d[`QDL_ST_BUSY] = (state_q != QDL_H_IDLE);
        rd_d[`QDL_ST_LOAD] = pulse_busy[`QDL_CTRL_LOAD];
        rd_d[`QDL_ST_CLEAR] = pulse_busy[`QDL_CTRL_CLEAR];
      end
      `QDL_REG_RX: rd_d = {16'h0000, rx_q};
      default: rd_d = '0;
    endcase
  end

  // One wait state so that ready and read data come from flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (access && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= ~mapped;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ****************************************
  // Load and clear pulses
  // ****************************************
  logic [`QDL_TMR_W-1:0] pcnt_q [2];
  logic [1:0] pulse_n_q;

  for (genvar i = 0; i < 2; i++) begin : g_pulse
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        pcnt_q[i] <= '0;
        pulse_n_q[i] <= 1'b1;
      end else if (pulse_req[i] && pcnt_q[i] == '0) begin
        pcnt_q[i] <= `QDL_TMR_W'(`QDL_PULSE_CYC);
        pulse_n_q[i] <= 1'b0;
      end else if (pcnt_q[i] != '0) begin
        pcnt_q[i] <= pcnt_q[i] - `QDL_TMR_W'(1);
        pulse_n_q[i] <= (pcnt_q[i] == `QDL_TMR_W'(1));
      end
    end
    assign pulse_busy[i] = ~pulse_n_q[i];
  end

  assign link.load_outputs_n = pulse_n_q[`QDL_CTRL_LOAD];
  assign link.clear_all_n = pulse_n_q[`QDL_CTRL_CLEAR];

  // ****************************************
  // Frame generator
  // ****************************************
  logic [`QDL_TMR_W-1:0] tmr_q;
  logic [`QDL_CNT_W-1:0] bit_q;
  qdl_word_t sh_q;
  logic half_done;
  logic fs_n_q;
  logic sclk_q;
  logic sdo_q;

  assign half_done = (tmr_q == `QDL_TMR_W'(`QDL_HALF_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_q == QDL_H_IDLE || half_done) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + `QDL_TMR_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_q <= '0;
    end else if (tx_start) begin
      tx_q <= pwdata[`QDL_WORD_BITS-1:0];
    end
  end

  // Shift clock idles low; data moves with the rising edge so it has half
  // a period of setup and of hold around each fall
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= QDL_H_IDLE;
      fs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      sdo_q <= 1'b0;
      sh_q <= '0;
      bit_q <= '0;
      rx_q <= '0;
    end else begin
      case (state_q)
        QDL_H_IDLE: begin
          if (tx_start) begin
            fs_n_q <= 1'b0;
            sdo_q <= pwdata[`QDL_WORD_BITS-1];
            sh_q <= {pwdata[`QDL_WORD_BITS-2:0], 1'b0};
            bit_q <= '0;
            state_q <= QDL_H_LEAD;
          end
        end
        QDL_H_LEAD: begin
          if (half_done) begin
            sclk_q <= 1'b1;
            state_q <= QDL_H_HIGH;
          end
        end
        QDL_H_HIGH: begin
          if (half_done) begin
            rx_q <= {rx_q[`QDL_WORD_BITS-2:0], chain_s};
            sclk_q <= 1'b0;
            state_q <= QDL_H_LOW;
          end
        end
        QDL_H_LOW: begin
          if (half_done && bit_q == `QDL_LAST_FALL) begin
            state_q <= QDL_H_TAIL;
          end else if (half_done) begin
            bit_q <= bit_q + `QDL_CNT_W'(1);
            sdo_q <= sh_q[`QDL_WORD_BITS-1];
            sh_q <= {sh_q[`QDL_WORD_BITS-2:0], 1'b0};
            sclk_q <= 1'b1;
            state_q <= QDL_H_HIGH;
          end
        end
        QDL_H_TAIL: begin
          if (half_done) begin
            fs_n_q <= 1'b1;
            sdo_q <= 1'b0;
            state_q <= QDL_H_IDLE;
          end
        end
        default: state_q <= QDL_H_IDLE;
      endcase
    end
  end

  assign link.frame_sync_n = fs_n_q;
  assign link.shift_clock_in = sclk_q;
  assign link.serial_in = sdo_q;

endmodule : qdl_host

/* File: test/qdl_link_properties.sv */
/*
 * Checker for the serial load link between host end and converter end.
 * Assumes the bench wires it beside the link interface, on clk_sys.
 */
`include "qdl_defs.svh"

module qdl_link_properties
  import qdl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link
  input wire logic frame_sync_n,
  input wire logic shift_clock_in,
  input wire logic serial_in,
  input wire logic serial_chain_out,
  input wire logic load_outputs_n,
  input wire logic clear_all_n,
  // Converter latches
  input wire qdl_code_t dac_a_q,
  input wire qdl_code_t dac_b_q,
  input wire qdl_code_t dac_c_q,
  input wire qdl_code_t dac_d_q
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Fall counter inside a frame
  // ****************************************
  logic sclk_q;
  logic [`QDL_CNT_W-1:0] falls_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= shift_clock_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || frame_sync_n) begin
      falls_q <= '0;
    end else if (sclk_q && !shift_clock_in) begin
      falls_q <= falls_q + `QDL_CNT_W'(1);
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  // Two sync stages plus the edge detect: the fall is first sampled three
  // edges before the chain output is seen to move
  property p_chain_after_fall;
    $changed(serial_chain_out) |->
      $past(shift_clock_in, 4) && !$past(shift_clock_in, 3) && !$past(shift_clock_in, 1);
  endproperty
  a_chain_after_fall: assert property (p_chain_after_fall)
    else $error("chain output moved without a shift clock fall");

  property p_chain_in_frame;
    $changed(serial_chain_out) |-> !$past(frame_sync_n, 3);
  endproperty
  a_chain_in_frame: assert property (p_chain_in_frame)
    else $error("chain output moved outside a frame");

  property p_frame_setup;
    $fell(frame_sync_n) |-> !shift_clock_in [*4] ##1 shift_clock_in;
  endproperty
  a_frame_setup: assert property (p_frame_setup)
    else $error("shift clock lead after frame start is wrong");

  property p_sclk_idle;
    frame_sync_n |-> !shift_clock_in;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("shift clock high outside a frame");

  property p_data_on_rise;
    $changed(serial_in) |-> $rose(shift_clock_in) || $changed(frame_sync_n);
  endproperty
  a_data_on_rise: assert property (p_data_on_rise)
    else $error("serial data changed away from a rising shift clock");

  property p_sixteen_falls;
    $rose(frame_sync_n) |-> falls_q == `QDL_FULL_CNT;
  endproperty
  a_sixteen_falls: assert property (p_sixteen_falls)
    else $error("frame did not carry sixteen falls");

  property p_clear_zero;
    $fell(clear_all_n) |-> ##3 ({dac_d_q, dac_c_q, dac_b_q, dac_a_q} == 48'h0000_0000_0000);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("clear did not zero the converter latches");

  property p_dac_cause;
    $changed({dac_d_q, dac_c_q, dac_b_q, dac_a_q}) |->
      !$past(load_outputs_n, 3) || !$past(clear_all_n, 3);
  endproperty
  a_dac_cause: assert property (p_dac_cause)
    else $error("converter latch changed without load or clear");
endmodule : qdl_link_properties

/* File: test/tb.sv */
/*
 * Bench joining host end and converter end over the link interface.
 * Assumes APB access to the host registers only; straps driven here.
 */
`include "qdl_defs.svh"

module tb
  import qdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic addr_pin_hi = 1'b0;
  logic addr_pin_lo = 1'b0;
  qdl_code_t dac_a_q, dac_b_q, dac_c_q, dac_d_q;
  qdl_code_t exp_code [4] = '{default: '0};
  qdl_code_t code;
  qdl_word_t word;
  qdl_word_t prev_word = '0;
  logic [1:0] sel;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  always #25 clk_sys = ~clk_sys;

  qdl_link_if link ();

  qdl_host i_qdl_host (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));

  qdl_device i_qdl_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .addr_pin_hi(addr_pin_hi), .addr_pin_lo(addr_pin_lo), .dac_a_q(dac_a_q),
    .dac_b_q(dac_b_q), .dac_c_q(dac_c_q), .dac_d_q(dac_d_q));

  qdl_link_properties i_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .frame_sync_n(link.frame_sync_n), .shift_clock_in(link.shift_clock_in),
    .serial_in(link.serial_in), .serial_chain_out(link.serial_chain_out),
    .load_outputs_n(link.load_outputs_n), .clear_all_n(link.clear_all_n),
    .dac_a_q(dac_a_q), .dac_b_q(dac_b_q), .dac_c_q(dac_c_q), .dac_d_q(dac_d_q));

  // ****************************************
  // Tasks
  // ****************************************
  task finish_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task check(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : check

  // One APB transfer; result left in rd and err
  task apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Poll until no frame or pulse is active, then let the latches settle
  task wait_idle;
    do apb(`QDL_REG_STATUS, 1'b0, '0); while (rd[2:0] !== 3'b000);
    repeat (4) @(posedge clk_sys);
  endtask : wait_idle

  // The device hands back the word it held before this frame
  task send(input qdl_word_t w);
    apb(`QDL_REG_TX, 1'b1, {16'h0000, w});
    wait_idle();
    apb(`QDL_REG_RX, 1'b0, '0);
    check({32'h0000_0000, rd[15:0]}, {32'h0000_0000, prev_word});
    prev_word = w;
  endtask : send

  task ctrl_check(input logic [1:0] ctl);
    apb(`QDL_REG_CTRL, 1'b1, {30'h0000_0000, ctl});
    wait_idle();
    check({dac_d_q, dac_c_q, dac_b_q, dac_a_q},
          {exp_code[3], exp_code[2], exp_code[1], exp_code[0]});
  endtask : ctrl_check

  // ****************************************
  // Sequence
  // ****************************************
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    ctrl_check(2'b00);
    $display("reset test done");
    // Every strap value against every address field; the select field is
    // spread so that the matching frames reach all four input latches
    for (int p = 0; p < 4; p++) begin
      for (int a = 0; a < 4; a++) begin
        addr_pin_hi <= p[1];
        addr_pin_lo <= p[0];
        sel = 2'(p + 2 * a);
        code = {p[1:0], a[1:0], 8'hc5};
        word = {code, a[1:0], sel};
        send(word);
        if (a == p) begin
          exp_code[sel] = code;
        end
        ctrl_check(2'b01);
      end
    end
    $display("address and select test done");
    // Clear wins over a load given together
    exp_code = '{default: '0};
    ctrl_check(2'b11);
    $display("clear test done");
    apb(8'h10, 1'b0, '0);
    check({15'h0000, err, rd}, {15'h0000, 1'b1, 32'h0000_0000});
    $display("unmapped test done");
    finish_test();
  end
endmodule : tb
